// ---- core/sfrb_pkg.sv ----
// Purpose: Shared constants for the bank 1 special register map.
// Assumes: Register index equals printed offset; byte address is four times the index.
// Notes: Unknown reset bits are given zero.
package sfrb_pkg;
    // ------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_IND = 8'h80;
    localparam logic [7:0] IDX_OPT = 8'h81;
    localparam logic [7:0] IDX_PCL = 8'h82;
    localparam logic [7:0] IDX_STAT = 8'h83;
    localparam logic [7:0] IDX_PTR = 8'h84;
    localparam logic [7:0] IDX_PORT_A_DIRECTION = 8'h85;
    localparam logic [7:0] IDX_PORT_B_DIRECTION = 8'h86;
    localparam logic [7:0] IDX_PORT_C_DIRECTION = 8'h87;
    localparam logic [7:0] IDX_PC_HIGH_LATCH = 8'h8A;
    localparam logic [7:0] IDX_INTC = 8'h8B;
    localparam logic [7:0] IDX_PIE = 8'h8C;
    localparam logic [7:0] IDX_RESET_CAUSE_FLAGS = 8'h8E;
    localparam logic [7:0] IDX_PR2 = 8'h92;
    localparam logic [7:0] IDX_SADDR = 8'h93;
    localparam logic [7:0] IDX_SSTAT = 8'h94;
    localparam logic [7:0] IDX_ADCFG = 8'h9F;
    // ------------------------------------------------------------
    // Address layout
    // ------------------------------------------------------------
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 9;
    localparam int BANK_BIT = 7;
    localparam int ADDR_W = 12;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ST_TO = 4;
    localparam int ST_PD = 3;
    localparam int RESET_CAUSE_FLAGS_POR = 1;
    localparam int RESET_CAUSE_FLAGS_BOR = 0;
    localparam int INTC_RBIF = 0;
    localparam logic [7:0] PTR_SELF_MASK = 8'h7F;
    localparam logic [7:0] PIE_MASK = 8'h4F;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ONES = 8'hFF;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [5:0] RST_PORT_A_DIRECTION = 6'h3F;
    localparam logic [7:0] RST_STAT_PUP = 8'h18;
    localparam logic [1:0] RST_RESET_CAUSE_FLAGS_POR = 2'h0;
    localparam logic [12:0] RST_PC = 13'h0000;
    localparam logic [4:0] RST_PC_HIGH_LATCH = 5'h00;
    localparam logic [5:0] RST_SSTAT = 6'h00;
    localparam logic [2:0] RST_ADCFG = 3'h0;
endpackage

// ---- core/sfrb_bank1_regs.sv ----
// Purpose: Bank 1 special register file behind an APB slave, with program counter and indirect port.
// Assumes: APB master keeps requests stable; external reset pin is asynchronous to clk.
// Notes: Read data is captured in the setup cycle, so pready is always high.
//
// Our own choice: the APB interface to the registers.
module sfrb_bank1_regs (
    // Clock and power-on reset
    input wire logic clk,
    input wire logic rstn,
    // Other reset sources
    input wire logic externalResetPinN,
    input wire logic watchdogExpire,
    input wire logic brownOutReq,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Indirect data memory port
    output logic [7:0] indAddr,
    output logic indWrEn,
    output logic [7:0] indWdata,
    input wire logic [7:0] indRdata,
    // Program counter control from core
    input wire logic pcStep,
    input wire logic pcLoad,
    input wire logic [7:0] pcLoadLow,
    output logic [12:0] pcValue,
    // Serial port state from peripheral
    input wire logic [5:0] serialStateIn,
    // Register values to peripherals
    output logic [7:0] optionOut,
    output logic [7:0] statusOut,
    output logic [5:0] trisAOut,
    output logic [7:0] trisBOut,
    output logic [7:0] trisCOut,
    output logic [7:0] intconOut,
    output logic [7:0] pieOut,
    output logic [7:0] pr2Out,
    output logic [7:0] slaveAddrOut,
    output logic [2:0] analogCfgOut
);
    // ------------------------------------------------------------
    // External reset pin synchroniser
    // ------------------------------------------------------------
    logic pinS1_q, pinS2_q, pinS3_q, pinStable_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pinS1_q <= 1'b1;
            pinS2_q <= 1'b1;
            pinS3_q <= 1'b1;
            pinStable_q <= 1'b1;
        end else begin
            pinS1_q <= externalResetPinN;
            pinS2_q <= pinS1_q;
            pinS3_q <= pinS2_q;
            if (pinS2_q == pinS3_q) begin
                pinStable_q <= pinS3_q;
            end
        end
    end

    // Other resets hold while the pin is low; brown-out takes the power values, except that it keeps the POR flag and clears only the BOR flag.
    wire otherReset = !pinStable_q || watchdogExpire;
    wire pupReset = brownOutReq;
    wire anyReset = otherReset || pupReset;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire [7:0] regIdx = paddr[sfrb_pkg::IDX_MSB:sfrb_pkg::IDX_LSB];
    wire [6:0] lowIdx = regIdx[6:0];
    wire addrOk = (paddr[1:0] == 2'h0) && (paddr[sfrb_pkg::ADDR_W-1:sfrb_pkg::IDX_MSB+1] == 2'h0);
    wire bank1 = regIdx[sfrb_pkg::BANK_BIT];
    // Mirrored locations ignore the bank bit.
    wire hitInd = addrOk && (lowIdx == sfrb_pkg::IDX_IND[6:0]);
    wire hitPcl = addrOk && (lowIdx == sfrb_pkg::IDX_PCL[6:0]);
    wire hitStat = addrOk && (lowIdx == sfrb_pkg::IDX_STAT[6:0]);
    wire hitPtr = addrOk && (lowIdx == sfrb_pkg::IDX_PTR[6:0]);
    wire hitPclath = addrOk && (lowIdx == sfrb_pkg::IDX_PC_HIGH_LATCH[6:0]);
    wire hitIntc = addrOk && (lowIdx == sfrb_pkg::IDX_INTC[6:0]);
    wire hitOpt = addrOk && bank1 && (regIdx == sfrb_pkg::IDX_OPT);
    wire hitTrisA = addrOk && bank1 && (regIdx == sfrb_pkg::IDX_PORT_A_DIRECTION);
    wire hitTrisB = addrOk && bank1 && (regIdx == sfrb_pkg::IDX_PORT_B_DIRECTION);
    wire hitTrisC = addrOk && bank1 && (regIdx == sfrb_pkg::IDX_PORT_C_DIRECTION);
    wire hitPie = addrOk && bank1 && (regIdx == sfrb_pkg::IDX_PIE);
    wire hitPcon = addrOk && bank1 && (regIdx == sfrb_pkg::IDX_RESET_CAUSE_FLAGS);
    wire hitPr2 = addrOk && bank1 && (regIdx == sfrb_pkg::IDX_PR2);
    wire hitSaddr = addrOk && bank1 && (regIdx == sfrb_pkg::IDX_SADDR);
    wire hitSstat = addrOk && bank1 && (regIdx == sfrb_pkg::IDX_SSTAT);
    wire hitAdcfg = addrOk && bank1 && (regIdx == sfrb_pkg::IDX_ADCFG);
    wire wrAcc = psel && penable && pwrite;
    wire rdSetup = psel && !penable && !pwrite;
    wire wrEn = wrAcc && !anyReset;
    wire [7:0] wrByte = pwdata[7:0];

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] opt_q, stat_q, ptr_q, port_b_direction_q, port_c_direction_q, intc_q, pie_q, pr2_q, saddr_q;
    logic [5:0] port_a_direction_q, sstat_q;
    logic [4:0] pc_high_latch_q;
    logic [1:0] reset_cause_flags_q;
    logic [2:0] adcfg_q;
    logic [12:0] pc_q;
    logic [31:0] prdata_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            opt_q <= sfrb_pkg::RST_ONES;
            port_a_direction_q <= sfrb_pkg::RST_PORT_A_DIRECTION;
            port_b_direction_q <= sfrb_pkg::RST_ONES;
            port_c_direction_q <= sfrb_pkg::RST_ONES;
            pr2_q <= sfrb_pkg::RST_ONES;
            saddr_q <= sfrb_pkg::RST_ZERO;
        end else if (anyReset) begin
            opt_q <= sfrb_pkg::RST_ONES;
            port_a_direction_q <= sfrb_pkg::RST_PORT_A_DIRECTION;
            port_b_direction_q <= sfrb_pkg::RST_ONES;
            port_c_direction_q <= sfrb_pkg::RST_ONES;
            pr2_q <= sfrb_pkg::RST_ONES;
            saddr_q <= sfrb_pkg::RST_ZERO;
        end else begin
            if (wrEn && hitOpt) opt_q <= wrByte;
            if (wrEn && hitTrisA) port_a_direction_q <= wrByte[5:0];
            if (wrEn && hitTrisB) port_b_direction_q <= wrByte;
            if (wrEn && hitTrisC) port_c_direction_q <= wrByte;
            if (wrEn && hitPr2) pr2_q <= wrByte;
            if (wrEn && hitSaddr) saddr_q <= wrByte;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pc_high_latch_q <= sfrb_pkg::RST_PC_HIGH_LATCH;
            pie_q <= sfrb_pkg::RST_ZERO;
            adcfg_q <= sfrb_pkg::RST_ADCFG;
            sstat_q <= sfrb_pkg::RST_SSTAT;
        end else if (anyReset) begin
            pc_high_latch_q <= sfrb_pkg::RST_PC_HIGH_LATCH;
            pie_q <= sfrb_pkg::RST_ZERO;
            adcfg_q <= sfrb_pkg::RST_ADCFG;
            sstat_q <= sfrb_pkg::RST_SSTAT;
        end else begin
            if (wrEn && hitPclath) pc_high_latch_q <= wrByte[4:0];
            if (wrEn && hitPie) pie_q <= wrByte & sfrb_pkg::PIE_MASK;
            if (wrEn && hitAdcfg) adcfg_q <= wrByte[2:0];
            sstat_q <= serialStateIn;
        end
    end

    // Pointer, interrupt control and status keep some contents across other resets.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ptr_q <= sfrb_pkg::RST_ZERO;
            intc_q <= sfrb_pkg::RST_ZERO;
            stat_q <= sfrb_pkg::RST_STAT_PUP;
            reset_cause_flags_q <= sfrb_pkg::RST_RESET_CAUSE_FLAGS_POR;
        end else if (pupReset) begin
            ptr_q <= sfrb_pkg::RST_ZERO;
            intc_q <= sfrb_pkg::RST_ZERO;
            stat_q <= sfrb_pkg::RST_STAT_PUP;
            reset_cause_flags_q[sfrb_pkg::RESET_CAUSE_FLAGS_BOR] <= 1'b0;
        end else if (otherReset) begin
            intc_q <= {7'h00, intc_q[sfrb_pkg::INTC_RBIF]};
            // Watchdog clears the time-out flag; the pin leaves both flags alone.
            stat_q <= {3'h0, watchdogExpire ? 1'b0 : stat_q[sfrb_pkg::ST_TO],
                       watchdogExpire ? 1'b1 : stat_q[sfrb_pkg::ST_PD], stat_q[2:0]};
        end else begin
            if (wrEn && hitPtr) ptr_q <= wrByte;
            if (wrEn && hitIntc) intc_q <= wrByte;
            // Time-out and power-down flags are not writable from the bus.
            if (wrEn && hitStat) begin
                stat_q <= {wrByte[7:5], stat_q[sfrb_pkg::ST_TO], stat_q[sfrb_pkg::ST_PD], wrByte[2:0]};
            end
            if (wrEn && hitPcon) reset_cause_flags_q <= wrByte[1:0];
        end
    end

    // ------------------------------------------------------------
    // Program counter
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pc_q <= sfrb_pkg::RST_PC;
        end else if (anyReset) begin
            pc_q <= sfrb_pkg::RST_PC;
        end else if (wrEn && hitPcl) begin
            pc_q <= {pc_high_latch_q, wrByte};
        end else if (pcLoad) begin
            pc_q <= {pc_high_latch_q, pcLoadLow};
        end else if (pcStep) begin
            pc_q <= pc_q + 13'h0001;
        end
    end

    // ------------------------------------------------------------
    // Indirect port and read path
    // ------------------------------------------------------------
    // A pointer naming the indirect location itself would loop, so it reads zero.
    wire ptrSelf = (ptr_q & sfrb_pkg::PTR_SELF_MASK) == sfrb_pkg::RST_ZERO;
    wire [7:0] indRead = ptrSelf ? sfrb_pkg::RST_ZERO : indRdata;
    assign indAddr = ptr_q;
    assign indWrEn = wrEn && hitInd && !ptrSelf;
    assign indWdata = wrByte;

    // Only the low program counter byte is on the map; unmatched addresses give zero.
    wire [7:0] readMux = ({8{hitInd}} & indRead) | ({8{hitOpt}} & opt_q)
        | ({8{hitPcl}} & pc_q[7:0]) | ({8{hitStat}} & stat_q)
        | ({8{hitPtr}} & ptr_q) | ({8{hitTrisA}} & {2'h0, port_a_direction_q})
        | ({8{hitTrisB}} & port_b_direction_q) | ({8{hitTrisC}} & port_c_direction_q)
        | ({8{hitPclath}} & {3'h0, pc_high_latch_q}) | ({8{hitIntc}} & intc_q)
        | ({8{hitPie}} & pie_q) | ({8{hitPcon}} & {6'h00, reset_cause_flags_q})
        | ({8{hitPr2}} & pr2_q) | ({8{hitSaddr}} & saddr_q)
        | ({8{hitSstat}} & {2'h0, sstat_q}) | ({8{hitAdcfg}} & {5'h00, adcfg_q});

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata_q <= 32'h00000000;
        end else if (rdSetup) begin
            prdata_q <= {24'h000000, readMux};
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign pcValue = pc_q;
    assign optionOut = opt_q;
    assign statusOut = stat_q;
    assign trisAOut = port_a_direction_q;
    assign trisBOut = port_b_direction_q;
    assign trisCOut = port_c_direction_q;
    assign intconOut = intc_q;
    assign pieOut = pie_q;
    assign pr2Out = pr2_q;
    assign slaveAddrOut = saddr_q;
    assign analogCfgOut = adcfg_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire anyHit = hitInd | hitOpt | hitPcl | hitStat | hitPtr | hitTrisA | hitTrisB | hitTrisC
        | hitPclath | hitIntc | hitPie | hitPcon | hitPr2 | hitSaddr | hitSstat | hitAdcfg;

    a_pcl_load_latch: assert property (wrEn && hitPcl |=> pc_q == {$past(pc_high_latch_q), $past(wrByte)})
        else $error("PC write did not merge latch");
    a_latch_no_jump: assert property (wrEn && hitPclath && !pcLoad && !pcStep |=> pc_q == $past(pc_q))
        else $error("Latch write moved the PC");
    a_mirror_status: assert property (rdSetup && hitStat && !bank1 |=> prdata_q[7:0] == $past(stat_q))
        else $error("Bank 0 status read mismatch");
    a_unmapped_zero: assert property (rdSetup && !anyHit |=> prdata_q == 32'h00000000)
        else $error("Unmapped read not zero");
    a_port_a_direction_upper: assert property (rdSetup && hitTrisA |=> prdata_q[7:6] == 2'h0)
        else $error("Unused direction bits not zero");
    a_wdt_values: assert property (watchdogExpire |=> opt_q == sfrb_pkg::RST_ONES && pr2_q == sfrb_pkg::RST_ONES
        && saddr_q == sfrb_pkg::RST_ZERO && !stat_q[sfrb_pkg::ST_TO])
        else $error("Watchdog reset values wrong");
    a_bor_values: assert property (brownOutReq |=> !reset_cause_flags_q[sfrb_pkg::RESET_CAUSE_FLAGS_BOR] && stat_q == sfrb_pkg::RST_STAT_PUP
        && ptr_q == sfrb_pkg::RST_ZERO)
        else $error("Brown-out reset values wrong");
    a_ind_redirect: assert property (rdSetup && hitInd && !ptrSelf |=> prdata_q[7:0] == $past(indRdata))
        else $error("Indirect read not redirected");

    c_ind_write: cover property (wrEn && hitInd && !ptrSelf);
    c_pc_load: cover property (pcLoad && !anyReset);
    c_pin_reset: cover property ($fell(pinStable_q));
endmodule // sfrb_bank1_regs

// ---- test/sfrb_data_mem.sv ----
// Purpose: Data memory model on the far side of the indirect port.
// Assumes: Read data follows the address combinationally.
// Notes: Contents start as the inverted address.
module sfrb_data_mem (
    // Clock
    input wire logic clk,
    // Indirect port
    input wire logic [7:0] indAddr,
    input wire logic indWrEn,
    input wire logic [7:0] indWdata,
    output logic [7:0] indRdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:255];
    // A start that is nonzero at every address but FF keeps a missed redirect from reading back as zero.
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = ~i[7:0];
        end
    end
    assign indRdata = mem[indAddr];
    always @(posedge clk) begin
        if (indWrEn) begin
            mem[indAddr] <= indWdata;
        end
    end
endmodule // sfrb_data_mem

// ---- test/tb_top.sv ----
// Purpose: Self-checking bench for the bank 1 register map.
// Assumes: Access phase answers at once; byte address is four times the index.
// Notes: The serial state input is held at one value.
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin error_cnt++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic wr; logic [7:0] wi; logic [7:0] ri; logic [7:0] wd; logic [7:0] ex;} sfrb_row_t;
    logic clk = 1'h0;
    logic rstn, externalResetPinN, watchdogExpire, brownOutReq, psel, penable, pwrite, pready, pslverr;
    logic indWrEn, pcStep, pcLoad;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] indAddr, indWdata, indRdata, pcLoadLow;
    logic [12:0] pcValue;
    logic [5:0] serialStateIn, trisAOut;
    logic [7:0] optionOut, statusOut, trisBOut, trisCOut, intconOut, pieOut, pr2Out, slaveAddrOut;
    logic [2:0] analogCfgOut;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    sfrb_row_t rows [0:22] = '{
        '{1'h0, 8'h00, 8'h81, 8'h00, 8'hFF}, '{1'h0, 8'h00, 8'h85, 8'h00, 8'h3F},
        '{1'h0, 8'h00, 8'h86, 8'h00, 8'hFF}, '{1'h0, 8'h00, 8'h87, 8'h00, 8'hFF},
        '{1'h0, 8'h00, 8'h92, 8'h00, 8'hFF}, '{1'h0, 8'h00, 8'h93, 8'h00, 8'h00},
        '{1'h0, 8'h00, 8'h83, 8'h00, 8'h18}, '{1'h0, 8'h00, 8'h8E, 8'h00, 8'h00},
        '{1'h0, 8'h00, 8'h94, 8'h00, 8'h2A}, '{1'h1, 8'h81, 8'h81, 8'h5A, 8'h5A},
        '{1'h1, 8'h85, 8'h85, 8'hFF, 8'h3F}, '{1'h1, 8'h9F, 8'h9F, 8'hFF, 8'h07},
        '{1'h1, 8'h8C, 8'h8C, 8'hFF, 8'h4F}, '{1'h1, 8'h8E, 8'h8E, 8'hFF, 8'h03},
        '{1'h1, 8'h93, 8'h93, 8'hC3, 8'hC3}, '{1'h1, 8'h88, 8'h88, 8'hFF, 8'h00},
        '{1'h1, 8'h9E, 8'h9E, 8'hFF, 8'h00}, '{1'h1, 8'h94, 8'h94, 8'h00, 8'h2A},
        '{1'h1, 8'h0A, 8'h8A, 8'h15, 8'h15}, '{1'h1, 8'h84, 8'h04, 8'h25, 8'h25},
        '{1'h1, 8'h0B, 8'h8B, 8'hFF, 8'hFF}, '{1'h1, 8'h83, 8'h03, 8'h07, 8'h1F},
        '{1'h1, 8'h05, 8'h05, 8'hFF, 8'h00}};

    sfrb_bank1_regs dut (.clk, .rstn, .externalResetPinN, .watchdogExpire, .brownOutReq, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .indAddr, .indWrEn, .indWdata, .indRdata,
        .pcStep, .pcLoad, .pcLoadLow, .pcValue, .serialStateIn, .optionOut, .statusOut, .trisAOut,
        .trisBOut, .trisCOut, .intconOut, .pieOut, .pr2Out, .slaveAddrOut, .analogCfgOut);
    sfrb_data_mem mem (.clk, .indAddr, .indWrEn, .indWdata, .indRdata);

    always #20 clk = ~clk;
    // ------------------------------------------------------------
    // Bus tasks and verdict
    // ------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] wd);
        @(posedge clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, wd};
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rd = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr8(input logic [7:0] i, input logic [7:0] d);
        xfer(1'h1, {2'h0, i, 2'h0}, d);
    endtask
    task automatic chk(input logic [7:0] i, input logic [7:0] ex);
        xfer(1'h0, {2'h0, i, 2'h0}, 8'h00);
        `CHK($sformatf("reg %h", i), {24'h000000, ex}, rd)
        `CHK("pslverr", 1'h0, pslverr)
    endtask
    task automatic results();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // A hang in a bus wait ends here rather than running forever.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            results();
        end
    end

    initial begin
        {rstn, psel, penable, pwrite, watchdogExpire, brownOutReq, pcStep, pcLoad} = 8'h00;
        externalResetPinN = 1'h1;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        pcLoadLow = 8'h00;
        serialStateIn = 6'h2A;
        repeat (16) @(posedge clk);
        `CHK("port_a_direction", 6'h3F, trisAOut)
        rstn <= 1'h1;
        foreach (rows[k]) begin
            if (rows[k].wr) wr8(rows[k].wi, rows[k].wd);
            chk(rows[k].ri, rows[k].ex);
        end
        `CHK("pc", 13'h0000, pcValue)
        @(posedge clk);
        pcLoadLow <= 8'h34;
        pcLoad <= 1'h1;
        @(posedge clk);
        pcLoad <= 1'h0;
        pcStep <= 1'h1;
        @(negedge clk);
        `CHK("pc", 13'h1534, pcValue)
        @(posedge clk);
        pcStep <= 1'h0;
        @(negedge clk);
        `CHK("pc", 13'h1535, pcValue)
        wr8(8'h82, 8'h77);
        @(posedge clk);
        @(negedge clk);
        `CHK("pc", 13'h1577, pcValue)
        chk(8'h02, 8'h77);
        for (logic [7:0] i = 8'h88; i < 8'h9F; i++) begin
            if (!(i inside {8'h8A, 8'h8B, 8'h8C, 8'h8E, 8'h92, 8'h93, 8'h94})) chk(i, 8'h00);
        end
        xfer(1'h1, 12'h205, 8'h00);
        xfer(1'h0, 12'h205, 8'h00);
        `CHK("misaligned", 32'h00000000, rd)
        chk(8'h81, 8'h5A);
        chk(8'h80, 8'hDA);
        wr8(8'h80, 8'h3C);
        chk(8'h00, 8'h3C);
        chk(8'h84, 8'h25);
        wr8(8'h84, 8'h80);
        chk(8'h80, 8'h00);
        @(posedge clk);
        watchdogExpire <= 1'h1;
        @(posedge clk);
        watchdogExpire <= 1'h0;
        chk(8'h83, 8'h0F);
        chk(8'h81, 8'hFF);
        chk(8'h8B, 8'h01);
        chk(8'h8A, 8'h00);
        chk(8'h84, 8'h80);
        chk(8'h93, 8'h00);
        chk(8'h8E, 8'h03);
        `CHK("pc", 13'h0000, pcValue)
        wr8(8'h86, 8'h00);
        wr8(8'h83, 8'h00);
        @(posedge clk);
        externalResetPinN <= 1'h0;
        repeat (8) @(posedge clk);
        externalResetPinN <= 1'h1;
        repeat (6) @(posedge clk);
        chk(8'h86, 8'hFF);
        chk(8'h83, 8'h08);
        brownOutReq <= 1'h1;
        @(posedge clk);
        brownOutReq <= 1'h0;
        chk(8'h8E, 8'h02);
        chk(8'h83, 8'h18);
        @(posedge clk);
        rstn <= 1'h0;
        repeat (2) @(posedge clk);
        rstn <= 1'h1;
        chk(8'h8E, 8'h00);
        chk(8'h81, 8'hFF);
        `CHK("pready", 1'h1, pready)
        `CHK("optionOut", 8'hFF, optionOut)
        `CHK("statusOut", 8'h18, statusOut)
        `CHK("trisBOut", 8'hFF, trisBOut)
        `CHK("trisCOut", 8'hFF, trisCOut)
        `CHK("intconOut", 8'h00, intconOut)
        `CHK("pieOut", 8'h00, pieOut)
        `CHK("pr2Out", 8'hFF, pr2Out)
        `CHK("slaveAddrOut", 8'h00, slaveAddrOut)
        `CHK("analogCfgOut", 3'h0, analogCfgOut)
        results();
    end
endmodule // tb_top
